// ---- fsfc_pkg.sv ----
package fsfc_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_SECURITY = 10'h001;
    localparam logic [9:0] IDX_CMD_INDEX = 10'h002;
    localparam logic [9:0] IDX_FACTORY = 10'h003;
    localparam logic [9:0] IDX_CONFIG = 10'h004;
    localparam logic [9:0] IDX_ERR_CONFIG = 10'h005;
    localparam logic [9:0] IDX_MOD_STATUS = 10'h006;
    localparam logic [9:0] IDX_ERR_STATUS = 10'h007;
    localparam logic [9:0] IDX_CMD_OBJECT = 10'h00a;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h010;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h011;
    localparam logic [9:0] IDX_CAPT_ADDR = 10'h012;
    localparam logic [9:0] IDX_CAPT_DATA = 10'h013;

    // security register fields
    localparam int SEC_BACKDOOR_KEY_ENABLE_MSB = 7;
    localparam int SEC_BACKDOOR_KEY_ENABLE_LSB = 6;
    localparam int SEC_STATE_MSB = 1;
    localparam int SEC_STATE_LSB = 0;
    localparam logic [1:0] BACKDOOR_KEY_ENABLE_ENABLED = 2'h2;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [7:0] SEC_ALL_SET = 8'hff;
    localparam logic [7:0] SEC_RESET = 8'hff;

    // configuration register fields and writable mask
    localparam int CFG_COMMAND_INTERRUPT_ENABLE = 7;
    localparam int CFG_IGNORE_SINGLE_FAULT = 4;
    localparam int CFG_FORCE_DOUBLE_FAULT = 1;
    localparam int CFG_FORCE_SINGLE_FAULT = 0;
    localparam logic [7:0] CFG_WMASK = 8'h93;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // error config, module status and error status fields
    localparam int ECFG_DOUBLE_FAULT_INTERRUPT_ENABLE = 1;
    localparam int ECFG_SINGLE_FAULT_INTERRUPT_ENABLE = 0;
    localparam int STAT_COMMAND_COMPLETE_FLAG = 7;
    localparam int ESTAT_DOUBLE_FAULT_FLAG = 1;
    localparam int ESTAT_SINGLE_FAULT_FLAG = 0;
    localparam logic [2:0] CMD_INDEX_RESET = 3'h0;
    localparam logic [15:0] CMD_WORD_RESET = 16'h0000;

    // interrupt status / mask bits
    localparam int EV_CMD_DONE = 0;
    localparam int EV_DBL_FAULT = 1;
    localparam int EV_SGL_FAULT = 2;
    localparam int EV_UNSECURE = 3;
    localparam int EV_WIDTH = 4;

    localparam int CMD_WORDS = 8;

    typedef struct packed {
        logic valid;
        logic [17:0] addr;
        logic [15:0] data;
        logic real_single;
        logic real_double;
    } fsfc_read_t;

    typedef struct packed {
        logic valid;
        logic [7:0] byte_value;
        logic dbl_fault;
    } fsfc_nvload_t;

endpackage

// ---- fsfc_regs.sv ----
// How it works
// [RULE_01] security register readable, writes ignored
// [RULE_02] security register loaded from nonvolatile byte
// [RULE_03] double fault at load sets all bits
// [RULE_04] only key code 10 enables backdoor
// [RULE_05] only security code 10 means unsecured
// [RULE_06] backdoor unsecure forces security code 10
// [RULE_07] three-bit index selects command word
// [RULE_08] factory register reads zero, ignores writes
// [RULE_09] four config bits writable, rest zero
// [RULE_10] command interrupt gated by enable bit
// [RULE_11] ignore bit suppresses single fault reporting
// [RULE_12] force double sets double flag per read
// [RULE_13] force single sets single flag per read
// [RULE_14] capture only on genuine faults
// [RULE_15] without force, flags need real faults
// [RULE_16] double fault interrupt gated by enable
// [RULE_17] complete flag, write one launches command
// [RULE_18] writable config bits reset to zero
`timescale 1ns/100ps
module fsfc_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fsfc_pkg::fsfc_nvload_t nv_load,
    input wire fsfc_pkg::fsfc_read_t array_read,
    input wire logic cmd_done,
    input wire logic backdoor_unsecure,
    output logic cmd_launch,
    output logic module_secured,
    output logic backdoor_enabled,
    output logic irq
);
    import fsfc_pkg::*;

    logic [7:0] security_reg;
    logic [2:0] cmd_index_reg;
    logic [7:0] config_reg;
    logic [1:0] err_config_reg;
    logic command_complete_flag_reg;
    logic double_fault_flag_reg;
    logic single_fault_flag_reg;
    logic [EV_WIDTH-1:0] irq_status_reg;
    logic [EV_WIDTH-1:0] irq_mask_reg;
    logic [17:0] capt_addr_reg;
    logic [15:0] capt_data_reg;
    logic [15:0] cmd_words [CMD_WORDS];
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic pslverr_next;
    logic cmd_launch_reg;
    logic irq_reg;
    logic irq_next;
    logic secured_reg;
    logic backdoor_key_enable_reg;

    logic setup;
    logic wr_done;
    logic [9:0] widx;
    logic aligned;
    logic mapped;
    logic set_double_fault_flag;
    logic set_single_fault_flag;
    logic real_sgl_seen;
    logic clr_double_fault_flag;
    logic clr_single_fault_flag;
    logic command_complete_flag_set;
    logic command_complete_flag_clr;
    logic [EV_WIDTH-1:0] ev_set;
    logic [EV_WIDTH-1:0] ev_clr;

    assign setup = psel & ~penable;
    assign wr_done = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    assign widx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);

    always_comb begin
        case (widx)
            IDX_SECURITY, IDX_CMD_INDEX, IDX_FACTORY, IDX_CONFIG,
            IDX_ERR_CONFIG, IDX_MOD_STATUS, IDX_ERR_STATUS, IDX_CMD_OBJECT,
            IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_CAPT_ADDR, IDX_CAPT_DATA: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end

    // no wait state: answer is ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= pslverr_next;
        end
    end

    assign pslverr_next = setup & ~mapped;

    always_comb begin
        prdata_next = 32'h0000_0000;
        if (setup && !pwrite && mapped) begin
            case (widx)
                // security register read path
                // [RULE_01] read-only view
                IDX_SECURITY: prdata_next[7:0] = security_reg;
                // [RULE_07] index field in low bits
                IDX_CMD_INDEX: prdata_next[2:0] = cmd_index_reg;
                // [RULE_08] always zero
                IDX_FACTORY: prdata_next = 32'h0000_0000;
                // [RULE_09] unimplemented bits zero
                IDX_CONFIG: prdata_next[7:0] = config_reg & CFG_WMASK;
                IDX_ERR_CONFIG: prdata_next[1:0] = err_config_reg;
                // [RULE_17] completion flag read
                IDX_MOD_STATUS: prdata_next[STAT_COMMAND_COMPLETE_FLAG] = command_complete_flag_reg;
                IDX_ERR_STATUS: prdata_next[1:0] = {double_fault_flag_reg, single_fault_flag_reg};
                IDX_CMD_OBJECT: prdata_next[15:0] = cmd_words[cmd_index_reg];
                IDX_IRQ_STATUS: prdata_next[EV_WIDTH-1:0] = irq_status_reg;
                IDX_IRQ_MASK: prdata_next[EV_WIDTH-1:0] = irq_mask_reg;
                IDX_CAPT_ADDR: prdata_next[17:0] = capt_addr_reg;
                IDX_CAPT_DATA: prdata_next[15:0] = capt_data_reg;
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // security register: secure from reset until the nonvolatile load or a backdoor unsecure arrives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            security_reg <= SEC_RESET;
        end else if (nv_load.valid) begin
            // [RULE_03] double fault secures
            if (nv_load.dbl_fault) begin
                security_reg <= SEC_ALL_SET;
            end else begin
                // [RULE_02] load from security byte
                security_reg <= nv_load.byte_value;
            end
        end else if (backdoor_unsecure) begin
            // [RULE_06] force unsecured code
            security_reg[SEC_STATE_MSB:SEC_STATE_LSB] <= SEC_UNSECURED;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secured_reg <= 1'b1;
            backdoor_key_enable_reg <= 1'b0;
        end else begin
            // [RULE_05] only code 10 unsecured
            secured_reg <= (security_reg[SEC_STATE_MSB:SEC_STATE_LSB] != SEC_UNSECURED);
            // [RULE_04] single enabling key code
            backdoor_key_enable_reg <= (security_reg[SEC_BACKDOOR_KEY_ENABLE_MSB:SEC_BACKDOOR_KEY_ENABLE_LSB] == BACKDOOR_KEY_ENABLE_ENABLED);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_index_reg <= CMD_INDEX_RESET;
        end else if (wr_done && widx == IDX_CMD_INDEX) begin
            // [RULE_07] upper bits dropped
            cmd_index_reg <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_done && widx == IDX_CMD_OBJECT) begin
            cmd_words[cmd_index_reg] <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // [RULE_18] clear on reset
            config_reg <= CFG_RESET;
            err_config_reg <= 2'h0;
        end else begin
            if (wr_done && widx == IDX_CONFIG) begin
                // [RULE_09] only writable bits stored
                config_reg <= pwdata[7:0] & CFG_WMASK;
            end
            if (wr_done && widx == IDX_ERR_CONFIG) begin
                err_config_reg <= pwdata[1:0];
            end
        end
    end

    // command completion flag: write one launches, completion sets
    assign command_complete_flag_clr = wr_done && widx == IDX_MOD_STATUS && pwdata[STAT_COMMAND_COMPLETE_FLAG] && command_complete_flag_reg;
    assign command_complete_flag_set = cmd_done & ~command_complete_flag_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_complete_flag_reg <= 1'b1;
            cmd_launch_reg <= 1'b0;
        end else begin
            cmd_launch_reg <= command_complete_flag_clr;
            // [RULE_17] launch clears, completion sets
            if (cmd_done) begin
                command_complete_flag_reg <= 1'b1;
            end else if (command_complete_flag_clr) begin
                command_complete_flag_reg <= 1'b0;
            end
        end
    end

    // fault flags on array reads
    always_comb begin
        set_double_fault_flag = 1'b0;
        set_single_fault_flag = 1'b0;
        real_sgl_seen = 1'b0;
        if (array_read.valid) begin
            // [RULE_15] real faults only when not forced
            // [RULE_12] forced double fault
            set_double_fault_flag = config_reg[CFG_FORCE_DOUBLE_FAULT] | array_read.real_double;
            // [RULE_11] ignore suppresses real single faults
            real_sgl_seen = array_read.real_single & ~config_reg[CFG_IGNORE_SINGLE_FAULT];
            // [RULE_13] forced single fault
            set_single_fault_flag = config_reg[CFG_FORCE_SINGLE_FAULT] | real_sgl_seen;
        end
    end

    assign clr_double_fault_flag = wr_done && widx == IDX_ERR_STATUS && pwdata[ESTAT_DOUBLE_FAULT_FLAG];
    assign clr_single_fault_flag = wr_done && widx == IDX_ERR_STATUS && pwdata[ESTAT_SINGLE_FAULT_FLAG];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            double_fault_flag_reg <= 1'b0;
        end else if (set_double_fault_flag) begin
            double_fault_flag_reg <= 1'b1;
        end else if (clr_double_fault_flag) begin
            double_fault_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_fault_flag_reg <= 1'b0;
        end else if (set_single_fault_flag) begin
            single_fault_flag_reg <= 1'b1;
        end else if (clr_single_fault_flag) begin
            single_fault_flag_reg <= 1'b0;
        end
    end

    // capture registers follow genuine faults only, double or non-ignored single
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capt_addr_reg <= 18'h00000;
            capt_data_reg <= 16'h0000;
        end else if (array_read.valid && (array_read.real_double || real_sgl_seen)) begin
            // [RULE_14] genuine fault capture
            capt_addr_reg <= array_read.addr;
            capt_data_reg <= array_read.data;
        end
    end

    // sticky event bits, write one to clear, set wins
    assign ev_set[EV_CMD_DONE] = command_complete_flag_set;
    assign ev_set[EV_DBL_FAULT] = set_double_fault_flag;
    assign ev_set[EV_SGL_FAULT] = set_single_fault_flag;
    assign ev_set[EV_UNSECURE] = backdoor_unsecure;
    assign ev_clr = (wr_done && widx == IDX_IRQ_STATUS) ? pwdata[EV_WIDTH-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= ev_set | (irq_status_reg & ~ev_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= '0;
        end else if (wr_done && widx == IDX_IRQ_MASK) begin
            irq_mask_reg <= pwdata[EV_WIDTH-1:0];
        end
    end

    always_comb begin
        irq_next = |(irq_status_reg & irq_mask_reg);
        // [RULE_10] completion interrupt enable
        irq_next = irq_next | (config_reg[CFG_COMMAND_INTERRUPT_ENABLE] & command_complete_flag_reg);
        // [RULE_16] double fault enable
        irq_next = irq_next | (err_config_reg[ECFG_DOUBLE_FAULT_INTERRUPT_ENABLE] & double_fault_flag_reg);
        irq_next = irq_next | (err_config_reg[ECFG_SINGLE_FAULT_INTERRUPT_ENABLE] & single_fault_flag_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cmd_launch = cmd_launch_reg;
    assign module_secured = secured_reg;
    assign backdoor_enabled = backdoor_key_enable_reg;
    assign irq = irq_reg;

endmodule

// ---- fsfc_regs_monitor.sv ----
`timescale 1ns/100ps
module fsfc_regs_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire fsfc_pkg::fsfc_nvload_t nv_load,
    input wire fsfc_pkg::fsfc_read_t array_read,
    input wire logic cmd_done,
    input wire logic backdoor_unsecure,
    input wire logic cmd_launch,
    input wire logic module_secured,
    input wire logic backdoor_enabled,
    input wire logic irq
);
    import fsfc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a:
        assert property (psel && !penable |=> pready) else $error("no pready after setup");
    idle_rdata_zero_a:
        assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
    factory_reads_zero_a:
        assert property (psel && penable && pready && !pwrite && paddr == 12'h00c |-> prdata == 32'h0)
            else $error("factory read not zero");
    index_upper_zero_a:
        assert property (psel && penable && pready && !pwrite && paddr == 12'h008 |-> prdata[31:3] == 29'h0)
            else $error("index upper bits set");
    config_unused_zero_a:
        assert property (psel && penable && pready && !pwrite && paddr == 12'h010 |-> (prdata & 32'hffffff6c) == 32'h0)
            else $error("config unused bits set");
    dbl_load_locks_a:
        assert property (nv_load.valid && nv_load.dbl_fault |-> ##2 module_secured && !backdoor_enabled)
            else $error("double fault load not secured");
    key_decode_a:
        assert property (nv_load.valid && !nv_load.dbl_fault |-> ##2
            backdoor_enabled == ($past(nv_load.byte_value[7:6], 2) == 2'h2)) else $error("key decode wrong");
    secure_decode_a:
        assert property (nv_load.valid && !nv_load.dbl_fault |-> ##2
            module_secured == ($past(nv_load.byte_value[1:0], 2) != 2'h2)) else $error("security decode wrong");
    unsecure_forces_a:
        assert property (backdoor_unsecure && !nv_load.valid |-> ##2 !module_secured)
            else $error("backdoor unsecure ignored");
    launch_pulse_a:
        assert property (cmd_launch |=> !cmd_launch) else $error("launch longer than one cycle");
    irq_quiet_reset_a:
        assert property ($rose(presetn) |-> !irq [*2]) else $error("irq after reset");
endmodule

// ---- fsfc_regs_test.sv ----
`timescale 1ns/100ps
module fsfc_regs_test;
    import fsfc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic cmd_done = 1'b0, backdoor_unsecure = 1'b0;
    logic pready, pslverr, cmd_launch, module_secured, backdoor_enabled, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, cap;
    logic [7:0] b;
    fsfc_nvload_t nv_load = '0;
    fsfc_read_t array_read = '0;
    int num_errors = 0, checked = 0, launches = 0;

    always #5 pclk = ~pclk;
    always @(posedge pclk) if (cmd_launch === 1'b1) launches <= launches + 1;

    fsfc_regs fsfc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nv_load(nv_load), .array_read(array_read), .cmd_done(cmd_done),
        .backdoor_unsecure(backdoor_unsecure), .cmd_launch(cmd_launch),
        .module_secured(module_secured), .backdoor_enabled(backdoor_enabled), .irq(irq));

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(a, 1'b0, 32'h0);
        check(name, rd, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge pclk);
    endtask

    task automatic load(input logic [7:0] v, input logic dbl);
        @(posedge pclk);
        nv_load <= {1'b1, v, dbl};
        @(posedge pclk);
        nv_load <= '0;
        settle();
    endtask

    task automatic aread(input logic [17:0] a, input logic s, input logic d);
        @(posedge pclk);
        array_read <= {1'b1, a, 16'h1234, s, d};
        @(posedge pclk);
        array_read <= '0;
        settle();
    endtask

    initial begin
        #100us;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h010, 32'h0, "config");
        rdc(12'h018, 32'h80, "status");
        check("irq", 32'(irq), 32'h0);
        wr(12'h004, 32'h0);
        rdc(12'h004, 32'hff, "security");
        wr(12'h00c, 32'hffffffff);
        rdc(12'h00c, 32'h0, "factory");
        wr(12'h008, 32'hffffffff);
        rdc(12'h008, 32'h7, "index");
        wr(12'h028, 32'hffffa5c3);
        wr(12'h008, 32'h2);
        wr(12'h028, 32'h00005a3c);
        rdc(12'h028, 32'h5a3c, "command word 2");
        wr(12'h008, 32'h7);
        rdc(12'h028, 32'ha5c3, "command word 7");
        wr(12'h010, 32'hffffffff);
        rdc(12'h010, 32'h93, "config");
        wr(12'h010, 32'h0);
        apb(12'h100, 1'b0, 32'h0);
        check("slverr", 32'(err), 32'h1);
        for (int i = 0; i < 16; i++) begin
            b = {i[3:2], 4'ha, i[1:0]};
            load(b, 1'b0);
            check("secured", 32'(module_secured), 32'(i[1:0] != 2'h2));
            check("backdoor_key_enable", 32'(backdoor_enabled), 32'(i[3:2] == 2'h2));
            rdc(12'h004, {24'h0, b}, "security");
        end
        load(8'h82, 1'b1);
        rdc(12'h004, 32'hff, "security");
        check("backdoor_key_enable", 32'(backdoor_enabled), 32'h0);
        @(posedge pclk);
        backdoor_unsecure <= 1'b1;
        @(posedge pclk);
        backdoor_unsecure <= 1'b0;
        settle();
        check("secured", 32'(module_secured), 32'h0);
        rdc(12'h004, 32'hfe, "security");
        rdc(12'h040, 32'h8, "irq status");
        wr(12'h044, 32'h8);
        settle();
        check("irq", 32'(irq), 32'h1);
        wr(12'h044, 32'h0);
        wr(12'h040, 32'h8);
        rdc(12'h040, 32'h0, "irq status");
        wr(12'h014, 32'h3);
        apb(12'h048, 1'b0, 32'h0);
        cap = rd;
        aread(18'h00abc, 1'b0, 1'b0);
        rdc(12'h01c, 32'h0, "err status");
        check("irq", 32'(irq), 32'h0);
        wr(12'h010, 32'h2);
        aread(18'h00001, 1'b0, 1'b0);
        rdc(12'h01c, 32'h2, "err status");
        check("irq", 32'(irq), 32'h1);
        rdc(12'h048, cap, "capture");
        wr(12'h01c, 32'h3);
        wr(12'h010, 32'h1);
        aread(18'h00002, 1'b0, 1'b0);
        rdc(12'h01c, 32'h1, "err status");
        check("irq", 32'(irq), 32'h1);
        wr(12'h01c, 32'h3);
        wr(12'h010, 32'h10);
        aread(18'h00003, 1'b1, 1'b0);
        rdc(12'h01c, 32'h0, "err status");
        check("irq", 32'(irq), 32'h0);
        wr(12'h010, 32'h0);
        aread(18'h00155, 1'b1, 1'b0);
        rdc(12'h01c, 32'h1, "err status");
        rdc(12'h048, 32'h155, "capture");
        rdc(12'h04c, 32'h1234, "capture data");
        wr(12'h01c, 32'h3);
        wr(12'h014, 32'h0);
        wr(12'h040, 32'hf);
        settle();
        check("irq", 32'(irq), 32'h0);
        wr(12'h010, 32'h80);
        settle();
        check("irq", 32'(irq), 32'h1);
        wr(12'h018, 32'h80);
        rdc(12'h018, 32'h0, "status");
        check("launches", 32'(launches), 32'h1);
        check("irq", 32'(irq), 32'h0);
        @(posedge pclk);
        cmd_done <= 1'b1;
        @(posedge pclk);
        cmd_done <= 1'b0;
        settle();
        check("irq", 32'(irq), 32'h1);
        rdc(12'h018, 32'h80, "status");
        wr(12'h010, 32'h93);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h010, 32'h0, "config");
        print_verdict();
    end
endmodule

bind fsfc_regs fsfc_regs_monitor fsfc_regs_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nv_load(nv_load), .array_read(array_read), .cmd_done(cmd_done),
    .backdoor_unsecure(backdoor_unsecure), .cmd_launch(cmd_launch), .module_secured(module_secured),
    .backdoor_enabled(backdoor_enabled), .irq(irq));
